/* File: logic/cpu_flags_regs.svh */
// Register offsets, field positions, reset values and opcode codes for the flag/branch block
`ifndef CPU_FLAGS_REGS_SVH
`define CPU_FLAGS_REGS_SVH
`define REG_CMD          8'h00
`define REG_OPERAND      8'h04
`define REG_RESULT       8'h08
`define REG_STATUS_WORD  8'h0C
`define REG_PC           8'h10
`define REG_SP           8'h14
`define REG_FIELD        8'h18
`define REG_ADDR_DECODE  8'h1C
`define REG_STACK_RAM    8'h20
`define CMD_OP_LSB       0
`define CMD_LEN_LSB      5
`define PSW_CARRY_BIT    7
`define PSW_HALF_BIT     6
`define PSW_PBANK_HI_BIT 4
`define PSW_PBANK_LO_BIT 3
`define PSW_WRAP_BIT     2
`define SP_RESET         8'h7F
`define PC_RESET         16'h0000
`define PSW_RESET        8'h00
`define SFR_SPACE_BIT    8
`define DIV_ZERO_QUOT    8'hFF
`define OP_NOP           5'h00
`define OP_ADD           5'h01
`define OP_ADDC          5'h02
`define OP_SUB           5'h03
`define OP_SUBC          5'h04
`define OP_MUL           5'h05
`define OP_DIV           5'h06
`define OP_ROL           5'h07
`define OP_ROR           5'h08
`define OP_ROTATE_LEFT_THRU_CARRY          5'h09
`define OP_ROTATE_RIGHT_THRU_CARRY          5'h0A
`define OP_BEQ           5'h0B
`define OP_BNE           5'h0C
`define OP_BZ            5'h0D
`define OP_BR_SHORT      5'h0E
`define OP_BR_LONG       5'h0F
`define OP_JMP_PAGE      5'h10
`define OP_JMP_FULL      5'h11
`define OP_CALL_PAGE     5'h12
`define OP_CALL_FULL     5'h13
`define OP_RET           5'h14
`define OP_CMP           5'h15
`endif

/* File: logic/cpu_flags_pkg.sv */
// Types shared by the flag/branch block and its bench
`default_nettype none
package cpu_flags_pkg;
  typedef struct packed {
    logic carry;
    logic half;
    logic wrap;
  } flags_s;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_PUSH_LO = 5'b00010,
    ST_PUSH_HI = 5'b00100,
    ST_POP_HI  = 5'b01000,
    ST_POP_LO  = 5'b10000
  } stack_state_e;
endpackage : cpu_flags_pkg
`default_nettype wire

/* File: logic/cpu_flags_branch_addressing.sv */
// Flag generation, branch decision, stack and program-address formation behind APB
//
// Added by the designer: the register addresses and the APB register port.
`include "cpu_flags_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module cpu_flags_branch_addressing #(
  parameter int STACK_DEPTH = 256
) (
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire logic                  coreClkEn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  output cpu_flags_pkg::flags_s      flagsOut,
  output logic      [15:0]           programCounter,
  output logic                       busy
);
  import cpu_flags_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  flags_s       flags;
  logic [1:0]   pointerBank;
  logic         ramBank;
  logic [7:0]   operandA;
  logic [7:0]   operandB;
  logic [15:0]  result;
  logic [15:0]  pc;
  logic [7:0]   stackPointer;
  logic [15:0]  field;
  logic [8:0]   directOperandAddress;
  logic [1:0]   pointerIndex;
  logic [7:0]   ramWinAddr;
  logic [15:0]  returnAddr;
  logic [7:0]   stackRam [STACK_DEPTH];
  stack_state_e state;
  stack_state_e next_state;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; zero wait states, unmapped addresses answer with an error
  logic access;
  logic wrEn;
  logic mapped;
  logic cmdGo;
  logic [4:0] cmdOp;
  logic [2:0] cmdLen;

  assign access = psel && penable;
  assign wrEn   = access && pwrite && coreClkEn;
  assign pready = 1'b1;
  assign mapped = (paddr == `REG_CMD) || (paddr == `REG_OPERAND) ||
                  (paddr == `REG_RESULT) || (paddr == `REG_STATUS_WORD) ||
                  (paddr == `REG_PC) || (paddr == `REG_SP) ||
                  (paddr == `REG_FIELD) || (paddr == `REG_ADDR_DECODE) ||
                  (paddr == `REG_STACK_RAM);
  assign pslverr = access && !mapped;
  // Commands written while a stack sequence runs are dropped, not queued
  assign cmdGo  = wrEn && (paddr == `REG_CMD) && (state == ST_IDLE);
  assign cmdOp  = pwdata[`CMD_OP_LSB +: 5];
  assign cmdLen = pwdata[`CMD_LEN_LSB +: 3];
  assign busy   = (state != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic and flag evaluation
  logic       cin;
  logic [8:0] sum9;
  logic [4:0] sumLo;
  logic [7:0] sum7;
  logic [8:0] diff9;
  logic [4:0] diffLo;
  logic [7:0] diff7;
  logic [15:0] product;
  logic [15:0] nextInstr;
  logic [15:0] pageTarget;
  logic [15:0] shortTarget;

  always_comb begin
    cin         = (cmdOp == `OP_ADDC || cmdOp == `OP_SUBC) ? flags.carry : 1'b0;
    sum9        = {1'b0, operandA} + {1'b0, operandB} + {8'h00, cin};
    sumLo       = {1'b0, operandA[3:0]} + {1'b0, operandB[3:0]} + {4'h0, cin};
    sum7        = {1'b0, operandA[6:0]} + {1'b0, operandB[6:0]} + {7'h00, cin};
    diff9       = {1'b0, operandA} - {1'b0, operandB} - {8'h00, cin};
    diffLo      = {1'b0, operandA[3:0]} - {1'b0, operandB[3:0]} - {4'h0, cin};
    diff7       = {1'b0, operandA[6:0]} - {1'b0, operandB[6:0]} - {7'h00, cin};
    product     = operandA * operandB;
    nextInstr   = pc + {13'h0000, cmdLen};
    pageTarget  = {nextInstr[15:12], field[11:0]};
    shortTarget = pc + {{8{field[7]}}, field[7:0]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: hardware results win over a software write in the same cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flags       <= '0;
      pointerBank <= 2'b00;
      ramBank     <= 1'b0;
    end else if (coreClkEn) begin
      if (wrEn && paddr == `REG_STATUS_WORD) begin
        flags.carry <= pwdata[`PSW_CARRY_BIT];
        flags.half  <= pwdata[`PSW_HALF_BIT];
        flags.wrap  <= pwdata[`PSW_WRAP_BIT];
        pointerBank <= pwdata[`PSW_PBANK_LO_BIT +: 2];
        ramBank     <= pwdata[1];
      end
      if (cmdGo) begin
        case (cmdOp)
          `OP_ADD, `OP_ADDC: begin
            flags.carry <= sum9[8];
            flags.half  <= sumLo[4];
            flags.wrap  <= sum9[8] ^ sum7[7];
          end
          `OP_SUB, `OP_SUBC: begin
            flags.carry <= diff9[8];
            flags.half  <= diffLo[4];
            flags.wrap  <= diff9[8] ^ diff7[7];
          end
          `OP_CMP: begin
            flags.carry <= diff9[8];
          end
          `OP_MUL: begin
            flags.carry <= 1'b0;
            flags.wrap  <= (product[15:8] != 8'h00);
          end
          `OP_DIV: begin
            flags.carry <= 1'b0;
            flags.wrap  <= (operandB == 8'h00);
          end
          `OP_ROTATE_LEFT_THRU_CARRY: begin
            flags.carry <= operandA[7];
          end
          `OP_ROTATE_RIGHT_THRU_CARRY: begin
            flags.carry <= operandA[0];
          end
          `OP_BEQ, `OP_BNE: begin
            flags.carry <= (operandB > operandA);
          end
          default: begin
            // Plain rotates, jumps and no-op leave flags alone
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operand and result registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      operandA <= 8'h00;
      operandB <= 8'h00;
      result   <= 16'h0000;
    end else if (coreClkEn) begin
      if (wrEn && paddr == `REG_OPERAND) begin
        operandA <= pwdata[7:0];
        operandB <= pwdata[15:8];
      end
      if (cmdGo) begin
        case (cmdOp)
          `OP_ADD, `OP_ADDC: result <= {8'h00, sum9[7:0]};
          `OP_SUB, `OP_SUBC: result <= {8'h00, diff9[7:0]};
          `OP_MUL:           result <= product;
          // Zero divisor gives a fixed quotient instead of trapping
          `OP_DIV: begin
            if (operandB == 8'h00) begin
              result <= {8'h00, `DIV_ZERO_QUOT};
            end else begin
              result <= {operandA % operandB, operandA / operandB};
            end
          end
          `OP_ROL:  result <= {8'h00, operandA[6:0], operandA[7]};
          `OP_ROR:  result <= {8'h00, operandA[0], operandA[7:1]};
          `OP_ROTATE_LEFT_THRU_CARRY: result <= {8'h00, operandA[6:0], flags.carry};
          `OP_ROTATE_RIGHT_THRU_CARRY: result <= {8'h00, flags.carry, operandA[7:1]};
          default: begin
            // No-op and control transfers keep the last result
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter: branch decisions and target formation
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pc         <= `PC_RESET;
      returnAddr <= 16'h0000;
    end else if (coreClkEn) begin
      if (wrEn && paddr == `REG_PC) begin
        pc <= pwdata[15:0];
      end
      if (cmdGo) begin
        case (cmdOp)
          `OP_BEQ: begin
            pc <= (operandA == operandB) ? shortTarget : nextInstr;
          end
          `OP_BNE: begin
            pc <= (operandA != operandB) ? shortTarget : nextInstr;
          end
          `OP_BZ: begin
            pc <= (operandA == 8'h00) ? shortTarget : nextInstr;
          end
          `OP_BR_SHORT: pc <= shortTarget;
          `OP_BR_LONG:  pc <= pc + field;
          `OP_JMP_PAGE: pc <= pageTarget;
          `OP_JMP_FULL: pc <= field;
          `OP_CALL_PAGE: begin
            returnAddr <= nextInstr;
            pc         <= pageTarget;
          end
          `OP_CALL_FULL: begin
            returnAddr <= nextInstr;
            pc         <= field;
          end
          `OP_RET: begin
            // PC is loaded by the pop sequence
          end
          default: pc <= nextInstr;
        endcase
      end
      if (state == ST_POP_HI) begin
        pc[15:8] <= stackRam[stackPointer];
      end
      if (state == ST_POP_LO) begin
        pc[7:0] <= stackRam[stackPointer];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack sequencer: one byte per cycle so each step is one RAM port access
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cmdGo && (cmdOp == `OP_CALL_PAGE || cmdOp == `OP_CALL_FULL)) begin
          next_state = ST_PUSH_LO;
        end else if (cmdGo && cmdOp == `OP_RET) begin
          next_state = ST_POP_HI;
        end
      end
      ST_PUSH_LO: next_state = ST_PUSH_HI;
      ST_PUSH_HI: next_state = ST_IDLE;
      ST_POP_HI:  next_state = ST_POP_LO;
      ST_POP_LO:  next_state = ST_IDLE;
      default:    next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= ST_IDLE;
    end else if (coreClkEn) begin
      state <= next_state;
    end
  end

  // Pointer is always a bank 0 address; the ram bank bit never reaches it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stackPointer <= `SP_RESET;
    end else if (coreClkEn) begin
      if (wrEn && paddr == `REG_SP) begin
        stackPointer <= pwdata[7:0];
      end
      if (state == ST_PUSH_LO || state == ST_PUSH_HI) begin
        stackPointer <= stackPointer + 8'h01;
      end
      if (state == ST_POP_HI || state == ST_POP_LO) begin
        stackPointer <= stackPointer - 8'h01;
      end
    end
  end

  // Push writes land one above the current pointer; APB window writes use the address in pwdata[15:8]
  always_ff @(posedge core_clk) begin
    if (coreClkEn) begin
      if (state == ST_PUSH_LO) begin
        stackRam[stackPointer + 8'h01] <= returnAddr[7:0];
      end else if (state == ST_PUSH_HI) begin
        stackRam[stackPointer + 8'h01] <= returnAddr[15:8];
      end else if (wrEn && paddr == `REG_STACK_RAM) begin
        stackRam[pwdata[15:8]] <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field, direct address and RAM window registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      field                <= 16'h0000;
      directOperandAddress <= 9'h000;
      pointerIndex         <= 2'b00;
      ramWinAddr           <= 8'h00;
    end else if (coreClkEn) begin
      if (wrEn && paddr == `REG_FIELD) begin
        field <= pwdata[15:0];
      end
      if (wrEn && paddr == `REG_ADDR_DECODE) begin
        directOperandAddress <= pwdata[8:0];
        pointerIndex         <= pwdata[10:9];
      end
      if (wrEn && paddr == `REG_STACK_RAM) begin
        ramWinAddr <= pwdata[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  logic        sfrSelect;
  logic [3:0]  pointerRamAddr;
  logic [7:0]  statusWord;

  assign sfrSelect      = directOperandAddress[`SFR_SPACE_BIT];
  assign pointerRamAddr = {pointerBank, pointerIndex};
  assign statusWord     = {flags.carry, flags.half, 1'b0, pointerBank, flags.wrap, ramBank,
                           1'b0};

  always_comb begin
    prdata = 32'h0000_0000;
    if (access && !pwrite) begin
      case (paddr)
        `REG_CMD:         prdata = {31'h0000_0000, busy};
        `REG_OPERAND:     prdata = {16'h0000, operandB, operandA};
        `REG_RESULT:      prdata = {16'h0000, result};
        `REG_STATUS_WORD: prdata = {24'h00_0000, statusWord};
        `REG_PC:          prdata = {16'h0000, pc};
        `REG_SP:          prdata = {24'h00_0000, stackPointer};
        `REG_FIELD:       prdata = {16'h0000, field};
        `REG_ADDR_DECODE: prdata = {12'h000, pointerRamAddr, 6'h00, !sfrSelect,
                                    sfrSelect, directOperandAddress[7:0]};
        `REG_STACK_RAM:   prdata = {16'h0000, ramWinAddr, stackRam[ramWinAddr]};
        default:          prdata = 32'h0000_0000;
      endcase
    end
  end

  assign flagsOut       = flags;
  assign programCounter = pc;
endmodule : cpu_flags_branch_addressing
`default_nettype wire

/* File: bench/apb_host_model.sv */
// APB master model: one transfer per start request
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
  input  wire logic        core_clk,
  input  wire logic        start,
  input  wire logic        isWr,
  input  wire logic [7:0]  reqAddr,
  input  wire logic [31:0] reqData,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic             done,
  output logic             err,
  output logic [31:0]      rdata
);
  // Idle bus at time zero
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    done = 1'h0;
  end
  // Setup, then access held until pready; released lines flip so stale data never looks valid
  always @(posedge core_clk) begin
    done <= 1'h0;
    if (start && !psel) begin
      psel <= 1'h1;
      pwrite <= isWr;
      paddr <= reqAddr;
      pwdata <= reqData;
    end else if (psel && !penable) begin
      penable <= 1'h1;
    end else if (psel && pready) begin
      psel <= 1'h0;
      penable <= 1'h0;
      paddr <= ~paddr;
      pwdata <= ~pwdata;
      rdata <= prdata;
      err <= pslverr;
      done <= 1'h1;
    end
  end
endmodule : apb_host_model
`default_nettype wire

/* File: bench/cpu_flags_monitor.sv */
// Port-level checker for flags, jumps and call/return timing
`timescale 1ns/1ps
`default_nettype none
`include "cpu_flags_regs.svh"
module cpu_flags_monitor (
  input wire logic                  core_clk,
  input wire logic                  reset,
  input wire logic                  coreClkEn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire cpu_flags_pkg::flags_s flagsOut,
  input wire logic [15:0]           programCounter,
  input wire logic                  busy
);
  import cpu_flags_pkg::*;
  logic        wrGo;
  logic        cmdGo;
  logic [4:0]  op;
  logic [15:0] ab;
  logic [15:0] fld;
  logic [8:0]  sum;
  logic [4:0]  low;
  logic [15:0] prod;
  logic [2:0]  addFl;
  logic        subBr;
  // Expected flags worked out from the operand shadow, not from the block
  assign wrGo = psel && penable && pwrite && coreClkEn;
  assign cmdGo = wrGo && paddr == `REG_CMD && !busy;
  assign op = pwdata[4:0];
  assign sum = {1'h0, ab[7:0]} + {1'h0, ab[15:8]};
  assign low = {1'h0, ab[3:0]} + {1'h0, ab[11:8]};
  assign prod = ab[7:0] * ab[15:8];
  assign addFl = {sum[8], low[4], ab[7] == ab[15] && sum[7] != ab[7]};
  assign subBr = ab[7:0] < ab[15:8];
  // Operand and field shadows
  always_ff @(posedge core_clk) begin
    if (wrGo && paddr == `REG_OPERAND) ab <= pwdata[15:0];
  end
  always_ff @(posedge core_clk) begin
    if (wrGo && paddr == `REG_FIELD) fld <= pwdata[15:0];
  end
  ////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_add_flags: assert property (cmdGo && op == `OP_ADD |=>
    flagsOut == $past(addFl)) else $error("add flags wrong");
  a_sub_borrow: assert property (cmdGo && (op == `OP_SUB || op == `OP_CMP) |=>
    flagsOut.carry == $past(subBr)) else $error("borrow flag wrong");
  a_muldiv_clear: assert property (cmdGo && (op == `OP_MUL || op == `OP_DIV) |=>
    !flagsOut.carry) else $error("carry not cleared");
  a_mul_wrap: assert property (cmdGo && op == `OP_MUL |=>
    flagsOut.wrap == ($past(prod) > 16'h00FF)) else $error("product wrap wrong");
  a_rotate_keep: assert property (cmdGo && (op == `OP_ROL || op == `OP_ROR) |=>
    $stable(flagsOut.carry)) else $error("plain rotate moved carry");
  a_nop_still: assert property (cmdGo && op == `OP_NOP |=>
    $stable(flagsOut)) else $error("nop changed flags");
  a_full_load: assert property (cmdGo && op == `OP_JMP_FULL |=>
    programCounter == fld) else $error("full target wrong");
  a_stack_busy: assert property (cmdGo && op inside {`OP_CALL_PAGE, `OP_RET} |=>
    busy [*2] ##1 !busy) else $error("stack sequence length wrong");
  // Main scenarios reached
  cover property (cmdGo && op == `OP_CALL_PAGE);
  cover property (cmdGo && op == `OP_RET);
  cover property (cmdGo && op == `OP_MUL);
endmodule : cpu_flags_monitor
bind cpu_flags_branch_addressing cpu_flags_monitor u_monitor (.core_clk, .reset, .coreClkEn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .flagsOut, .programCounter, .busy);
`default_nettype wire

/* File: bench/cpu_flags_branch_addressing_bench.sv */
// Self-checking bench driving the block through the APB host model
`timescale 1ns/1ps
`default_nettype none
`include "cpu_flags_regs.svh"
module cpu_flags_branch_addressing_bench;
  import cpu_flags_pkg::*;
  logic        core_clk = 1'h0;
  logic        reset = 1'h1;
  logic        coreClkEn = 1'h1;
  logic        start = 1'h0;
  logic        isWr = 1'h0;
  logic [7:0]  reqAddr = 8'h00;
  logic [31:0] reqData = 32'h0;
  logic        psel, penable, pwrite, pready, pslverr, busy, done, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata, rd;
  flags_s      flagsOut;
  logic [15:0] programCounter;
  int          miscompares = 0;
  int          samples_checked = 0;
  cpu_flags_branch_addressing DUT (.core_clk, .reset, .coreClkEn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .flagsOut, .programCounter, .busy);
  apb_host_model host (.core_clk, .start, .isWr, .reqAddr, .reqData, .pready, .pslverr,
    .prdata, .psel, .penable, .pwrite, .paddr, .pwdata, .done, .err, .rdata);
  ////////////////////////////////////////
  task automatic finish_test;
    if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One bus transfer; a hung slave ends the run
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    start <= 1'h1;
    isWr <= w;
    reqAddr <= a;
    reqData <= d;
    @(posedge core_clk);
    start <= 1'h0;
    while (done !== 1'h1) begin
      @(posedge core_clk);
      n++;
      if (n > 20) begin
        miscompares++;
        finish_test();
      end
    end
    rd = rdata;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(nm, exp, rd);
  endtask : rdc
  task automatic go(input logic [4:0] c, input logic [15:0] ab, input logic [2:0] len);
    wr(`REG_OPERAND, {16'h0, ab});
    wr(`REG_CMD, {24'h0, len, c});
  endtask : go
  // Arithmetic op, then result (low byte unless 16-bit op) and status
  task automatic run(input logic [4:0] c, input logic [15:0] ab, input logic [15:0] res,
                     input logic [7:0] sw);
    logic [15:0] m;
    m = (c == `OP_MUL || c == `OP_DIV) ? 16'hFFFF : 16'h00FF;
    go(c, ab, 3'h2);
    apb(1'h0, `REG_RESULT, 32'h0);
    chk("result", {16'h0, res}, {16'h0, rd[15:0] & m});
    rdc("status", `REG_STATUS_WORD, {24'h0, sw});
  endtask : run
  ////////////////////////////////////////
  task automatic t_arith;
    wr(`REG_STATUS_WORD, 32'h0);
    run(`OP_ADD, 16'h1355, 16'h0068, 8'h00);
    run(`OP_ADD, 16'h0A68, 16'h0072, 8'h40);
    run(`OP_ADD, 16'h0F72, 16'h0081, 8'h44);
    run(`OP_ADD, 16'h8081, 16'h0001, 8'h84);
    run(`OP_SUB, 16'h2010, 16'h00F0, 8'h80);
    run(`OP_SUB, 16'h0180, 16'h007F, 8'h44);
    run(`OP_CMP, 16'h0605, 16'h007F, 8'hC4);
    run(`OP_MUL, 16'h1010, 16'h0100, 8'h44);
    run(`OP_MUL, 16'h110F, 16'h00FF, 8'h40);
    run(`OP_DIV, 16'h0000, 16'h00FF, 8'h44);
    run(`OP_DIV, 16'h0707, 16'h0001, 8'h40);
    run(`OP_ROR, 16'h0001, 16'h0080, 8'h40);
    run(`OP_ROTATE_LEFT_THRU_CARRY, 16'h0080, 16'h0000, 8'hC0);
    run(`OP_ROL, 16'h0001, 16'h0002, 8'hC0);
    run(`OP_ROTATE_RIGHT_THRU_CARRY, 16'h0002, 16'h0081, 8'h40);
    // Carry-in variants: the borrow or carry from the previous step must take part
    run(`OP_SUB, 16'h0100, 16'h00FF, 8'hC0);
    run(`OP_SUBC, 16'h0500, 16'h00FA, 8'hC0);
    run(`OP_ADDC, 16'h0101, 16'h0003, 8'h00);
  endtask : t_arith
  // Branch decisions, relative and absolute targets, no-operation
  task automatic t_flow;
    wr(`REG_STATUS_WORD, 32'h98);
    wr(`REG_PC, 32'h0100);
    wr(`REG_FIELD, 32'h0080);
    go(`OP_BEQ, 16'h3333, 3'h3);
    rdc("beq pc", `REG_PC, 32'h0080);
    rdc("beq flag", `REG_STATUS_WORD, 32'h18);
    go(`OP_BNE, 16'h3433, 3'h3);
    rdc("bne pc", `REG_PC, 32'h0000);
    go(`OP_BEQ, 16'h3433, 3'h3);
    rdc("beq skip", `REG_PC, 32'h0003);
    go(`OP_NOP, 16'h0000, 3'h1);
    rdc("nop pc", `REG_PC, 32'h0004);
    rdc("nop flag", `REG_STATUS_WORD, 32'h98);
    wr(`REG_PC, 32'hF000);
    wr(`REG_FIELD, 32'h2000);
    go(`OP_BR_LONG, 16'h0, 3'h3);
    rdc("long pc", `REG_PC, 32'h1000);
    wr(`REG_PC, 32'h1FFE);
    wr(`REG_FIELD, 32'h0123);
    go(`OP_JMP_PAGE, 16'h0, 3'h2);
    rdc("page pc", `REG_PC, 32'h2123);
    wr(`REG_FIELD, 32'hABCD);
    go(`OP_JMP_FULL, 16'h0, 3'h3);
    rdc("full pc", `REG_PC, 32'hABCD);
    wr(`REG_FIELD, 32'h0010);
    go(`OP_BZ, 16'h0500, 3'h2);
    rdc("bz taken", `REG_PC, 32'hABDD);
    go(`OP_BZ, 16'h0005, 3'h2);
    rdc("bz skip", `REG_PC, 32'hABDF);
    wr(`REG_FIELD, 32'h00F0);
    go(`OP_BR_SHORT, 16'h0, 3'h2);
    rdc("short back", `REG_PC, 32'hABCF);
  endtask : t_flow
  // Call and return with another RAM bank selected, then a table jump
  task automatic t_stack;
    wr(`REG_STATUS_WORD, 32'h02);
    wr(`REG_PC, 32'h1234);
    wr(`REG_FIELD, 32'h0F00);
    go(`OP_CALL_PAGE, 16'h0, 3'h2);
    rdc("call pc", `REG_PC, 32'h1F00);
    rdc("call sp", `REG_SP, 32'h81);
    go(`OP_RET, 16'h0, 3'h1);
    rdc("ret pc", `REG_PC, 32'h1236);
    rdc("ret sp", `REG_SP, 32'h7F);
    wr(`REG_STACK_RAM, 32'h0713);
    wr(`REG_STACK_RAM, 32'h080C);
    wr(`REG_SP, 32'h08);
    go(`OP_RET, 16'h0, 3'h1);
    rdc("table pc", `REG_PC, 32'h0C13);
    rdc("table sp", `REG_SP, 32'h06);
    wr(`REG_FIELD, 32'h4321);
    go(`OP_CALL_FULL, 16'h0, 3'h3);
    rdc("callf pc", `REG_PC, 32'h4321);
    go(`OP_RET, 16'h0, 3'h1);
    rdc("callf ret", `REG_PC, 32'h0C16);
  endtask : t_stack
  // Address decode, unmapped access, frozen clock enable
  task automatic t_misc;
    wr(`REG_STATUS_WORD, 32'h10);
    wr(`REG_ADDR_DECODE, 32'h06FF);
    rdc("ram decode", `REG_ADDR_DECODE, 32'h000B02FF);
    wr(`REG_ADDR_DECODE, 32'h0100);
    rdc("sfr decode", `REG_ADDR_DECODE, 32'h00080100);
    apb(1'h0, 8'h40, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    coreClkEn <= 1'h0;
    wr(`REG_SP, 32'h55);
    coreClkEn <= 1'h1;
    rdc("frozen sp", `REG_SP, 32'h06);
  endtask : t_misc
  // Free-running clock
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'h0;
    @(posedge core_clk);
    rdc("reset sp", `REG_SP, 32'h7F);
    rdc("reset pc", `REG_PC, 32'h0);
    t_arith();
    t_flow();
    t_stack();
    t_misc();
    finish_test();
  end
endmodule : cpu_flags_branch_addressing_bench
`default_nettype wire
